// ==== hdl/ext_bus_unit.sv ====
// How it works
// - drive 26-bit word address on address pins 27 to 2
// - on 8/16-bit buses put address bits 1 and 0 on lanes 2 and 3
// - bus grant releases address pins, which feed select and wait logic
// - granted address gets bits 31 to 28 forced to zero
// - with DRAM on, row then column go on address pins 13 to 2
// - a 4-bit space identifier goes out with every own access while pin select is high
// - space pins carry identifier when pin select high, else address 28..31
// - space pins switch with the address pins at cycle start, but hold at the DRAM column switch
// - granted with select low, space pins are inputs, upper bits zero
// - cycle strobe low for exactly the first clock of each cycle
// - cycle starts at strobe, ends on external or generated ready
// - granted master's strobe triggers select and wait logic
// - range selects need a range hit and the select enable bit
// - boot select has no range and is always enabled
// - each range has a wait count; ready generated when it elapses
// - 32-bit two-way data bus, driven on writes, sampled on reads
// - accesses aligned by size: half even, word 4, double 8
// - 8-bit bus uses data 7:0, 16-bit bus uses data 15:0
// - all bus timing taken from the core clock input
`timescale 1ns/1ps
`include "ebus_defs.svh"
module ext_bus_unit (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // core side requests
    input wire logic i_req,
    input wire ebus_pkg::addr_t i_req_addr,
    input wire logic [`SID_W-1:0] i_req_asi,
    input wire logic i_req_write,
    input wire logic [1:0] i_req_size,
    input wire logic [31:0] i_req_wdata,
    input wire logic [31:0] i_req_wdata2,
    output logic o_busy,
    output logic o_granted,
    output logic o_ack,
    output logic [31:0] o_rdata,
    output logic o_misalign,
    // configuration
    input wire logic [1:0] i_bus_width,
    input wire logic i_dram_enable,
    input wire logic i_select_enable,
    input wire ebus_pkg::range_arr_t i_range_base_setting,
    input wire ebus_pkg::range_arr_t i_range_mask,
    input wire ebus_pkg::wait_arr_t i_wait_count,
    // pins
    input wire logic [`WADR_W-1:0] i_address_in,
    output logic [`WADR_W-1:0] o_address_out,
    output logic o_address_oe,
    input wire logic [`SID_W-1:0] i_space_in,
    output logic [`SID_W-1:0] o_space_out,
    output logic o_space_oe,
    input wire logic i_space_pin_select,
    input wire logic i_cycle_strobe_n,
    output logic o_cycle_strobe_n,
    output logic o_cycle_strobe_oe,
    output logic o_byte_lane2_enable_n,
    output logic o_byte_lane3_enable_n,
    input wire logic [31:0] i_data_in,
    output logic [31:0] o_data_out,
    output logic [31:0] o_data_oe,
    input wire logic i_ready_n,
    output logic o_generated_ready_n,
    output logic o_boot_select_n,
    output logic [`RANGE_CNT-1:0] o_range_select_n,
    input wire logic i_bus_grant
);
    import ebus_pkg::*;

    // pin stages start at the idle pin levels, so no false strobe or ready follows reset
    localparam pins_s PINS_IDLE = '{strobe_n: `INACTIVE_N, ready_n: `INACTIVE_N,
        psel: `INACTIVE_N, default: '0};

    localparam bus_s BUS_RESET = '{state: ST_IDLE, s1: PINS_IDLE, s2: PINS_IDLE,
        strobe_n: `INACTIVE_N,
        lane2_n: `INACTIVE_N, lane3_n: `INACTIVE_N, gen_rdy_n: `INACTIVE_N,
        boot_n: `INACTIVE_N, range_n: {`RANGE_CNT{`INACTIVE_N}}, default: '0};

    bus_s q;
    bus_s d;
    addr_t start_addr;
    cs_if cs();

    range_decode u_decode (
        .bus(cs)
    );

    function automatic logic aligned(logic [1:0] sz, addr_t a);
        unique case (sz)
            `SIZE_BYTE: return 1'b1;
            `SIZE_HALF: return !a[0];
            `SIZE_WORD: return a[1:0] == 2'h0;
            `SIZE_DOUBLE: return a[2:0] == 3'h0;
        endcase
    endfunction : aligned

    // data lines in use for a bus width
    function automatic logic [31:0] width_mask(logic [1:0] w);
        if (w == `WIDTH_8) begin
            return `MASK_8;
        end else if (w == `WIDTH_16) begin
            return `MASK_16;
        end
        return `MASK_32;
    endfunction : width_mask

    // active-low lane 2 and 3 enables
    function automatic logic [1:0] lanes(logic [1:0] w, logic [1:0] sz, logic [1:0] a);
        logic en2;
        logic en3;
        en2 = (sz >= `SIZE_WORD) || (sz == `SIZE_HALF && a[1]) || (a == `LANE2);
        en3 = (sz >= `SIZE_WORD) || (sz == `SIZE_HALF && a[1]) || (a == `LANE3);
        if (w != `WIDTH_32) begin
            return a;
        end
        return {~en2, ~en3};
    endfunction : lanes

    // narrow writes move the addressed big-endian byte or half to the low lines
    function automatic logic [31:0] place(logic [1:0] w, logic [1:0] a, logic [31:0] wd);
        logic [31:0] sh;
        sh = wd;
        if (w == `WIDTH_8) begin
            sh = wd >> {~a, 3'h0};
        end else if (w == `WIDTH_16) begin
            sh = wd >> {~a[1], 4'h0};
        end
        return sh & width_mask(w);
    endfunction : place

    // load an own cycle and drive its first clock
    function automatic bus_s start_cycle(bus_s s, addr_t a, logic [`SID_W-1:0] asi,
            logic wr, logic [1:0] sz, logic [1:0] w, logic dram, logic psel,
            logic [31:0] wd);
        bus_s r;
        r = s;
        r.addr = a;
        r.asi = asi;
        r.write = wr;
        r.size = sz;
        r.width = w;
        r.dram = dram;
        r.psel = psel;
        r.second = 1'b0;
        r.grant_cyc = 1'b0;
        r.cnt = '0;
        r.state = ST_WAIT;
        r.adr_out = {a[`WADR_MSB:`DRAM_ROW_LSB],
            dram ? a[`DRAM_ROW_MSB:`DRAM_ROW_LSB] : a[`DRAM_COL_MSB:`WADR_LSB]};
        r.sid_out = psel ? asi : {a[28], a[29], a[30], a[31]};
        r.adr_oe = 1'b1;
        r.sid_oe = 1'b1;
        r.strobe_oe = 1'b1;
        r.strobe_n = 1'b0;
        {r.lane2_n, r.lane3_n} = lanes(w, sz, a[1:0]);
        r.dat_out = place(w, a[1:0], wd);
        r.dat_oe = wr ? width_mask(w) : '0;
        return r;
    endfunction : start_cycle

    // decode the starting address in idle, the held one during a cycle
    assign start_addr = q.s2.grant ? {`TOP_ZERO, q.s2.wadr, 2'h0} : i_req_addr;
    assign cs.addr = (q.state == ST_IDLE) ? start_addr : q.addr;
    assign cs.enable = i_select_enable;
    assign cs.base = i_range_base_setting;
    assign cs.mask = i_range_mask;
    assign cs.waits = i_wait_count;

    // next state of the whole unit
    always_comb begin
        d = q;
        d.s1 = '{wadr: i_address_in, sid: i_space_in, strobe_n: i_cycle_strobe_n,
            ready_n: i_ready_n, data: i_data_in, grant: i_bus_grant,
            psel: i_space_pin_select};
        d.s2 = q.s1;
        d.ack = 1'b0;
        d.misalign = 1'b0;
        d.gen_rdy_n = `INACTIVE_N;
        unique case (q.state)
            ST_IDLE: begin
                // address pins hold their last value between cycles
                d.adr_oe = !q.s2.grant;
                d.sid_oe = !q.s2.grant;
                d.strobe_oe = !q.s2.grant;
                d.dat_oe = '0;
                if (q.s2.grant) begin
                    if (!q.s2.strobe_n) begin
                        d.addr = start_addr;
                        d.asi = q.s2.psel ? '0 : q.s2.sid;
                        d.grant_cyc = 1'b1;
                        d.second = 1'b0;
                        d.cnt = '0;
                        d.lim = cs.lim;
                        d.boot_n = !cs.sel[`BOOT_SEL];
                        d.range_n = ~cs.sel[`SEL_CNT-1:1];
                        d.state = ST_WAIT;
                    end
                end else if (i_req) begin
                    if (!aligned(i_req_size, i_req_addr)) begin
                        d.misalign = 1'b1;
                    end else begin
                        d = start_cycle(d, i_req_addr, i_req_asi, i_req_write, i_req_size,
                            i_bus_width, i_dram_enable, q.s2.psel, i_req_wdata);
                        d.wdata2 = i_req_wdata2;
                        d.lim = cs.lim;
                        d.boot_n = !cs.sel[`BOOT_SEL];
                        d.range_n = ~cs.sel[`SEL_CNT-1:1];
                    end
                end
            end
            ST_WAIT: begin
                d.strobe_n = `INACTIVE_N;
                d.cnt = q.cnt + 1'b1;
                if (q.dram && !q.grant_cyc && q.cnt == '0) begin
                    d.adr_out[`DRAM_W-1:0] = q.addr[`DRAM_COL_MSB:`WADR_LSB];
                end
                if (q.cnt == q.lim) begin
                    d.gen_rdy_n = 1'b0;
                    d.state = ST_DONE;
                end else if (!q.s2.ready_n) begin
                    d.state = ST_DONE;
                end
            end
            ST_DONE: begin
                d.cnt = '0;
                d.dat_oe = '0;
                d.state = ST_IDLE;
                if (!q.grant_cyc) begin
                    d.ack = 1'b1;
                    d.rdata = q.s2.data & width_mask(q.width);
                end
                if (!q.grant_cyc && q.size == `SIZE_DOUBLE && !q.second) begin
                    d = start_cycle(d, q.addr + `WORD_STEP, q.asi, q.write, q.size,
                        q.width, q.dram, q.psel, q.wdata2);
                    d.second = 1'b1;
                end else begin
                    d.boot_n = `INACTIVE_N;
                    d.range_n = {`RANGE_CNT{`INACTIVE_N}};
                    // a grant that came mid cycle takes the pins as the cycle ends
                    d.adr_oe = !q.s2.grant;
                    d.sid_oe = !q.s2.grant;
                    d.strobe_oe = !q.s2.grant;
                end
            end
        endcase
        d.busy = d.state != ST_IDLE;
        d.granted = q.s2.grant;
    end

    // single register of all state, on the core clock
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= BUS_RESET;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign o_busy = q.busy;
    assign o_granted = q.granted;
    assign o_ack = q.ack;
    assign o_rdata = q.rdata;
    assign o_misalign = q.misalign;
    assign o_address_out = q.adr_out;
    assign o_address_oe = q.adr_oe;
    assign o_space_out = q.sid_out;
    assign o_space_oe = q.sid_oe;
    assign o_cycle_strobe_n = q.strobe_n;
    assign o_cycle_strobe_oe = q.strobe_oe;
    assign o_byte_lane2_enable_n = q.lane2_n;
    assign o_byte_lane3_enable_n = q.lane3_n;
    assign o_data_out = q.dat_out;
    assign o_data_oe = q.dat_oe;
    assign o_generated_ready_n = q.gen_rdy_n;
    assign o_boot_select_n = q.boot_n;
    assign o_range_select_n = q.range_n;

    // checks on the unit's own behaviour
    strobe_one_clk_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(o_cycle_strobe_n) |=> o_cycle_strobe_n && o_busy)
        else $error("strobe low for more than one clock");

    grant_release_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        o_granted && !o_busy |-> !o_address_oe && !o_space_oe && !o_cycle_strobe_oe)
        else $error("pins driven while granted and idle");

    grant_top_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        q.grant_cyc && o_busy |-> q.addr[31:28] == `TOP_ZERO)
        else $error("granted address top bits not zero");

    space_pin_map_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(o_cycle_strobe_n) |-> o_space_out == (q.psel ? q.asi
            : {q.addr[28], q.addr[29], q.addr[30], q.addr[31]}))
        else $error("space pins carry wrong source");

    lane_narrow_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        !o_cycle_strobe_n && q.width != `WIDTH_32
        |-> {o_byte_lane2_enable_n, o_byte_lane3_enable_n} == q.addr[1:0])
        else $error("lanes 2 and 3 do not carry address bits 1 and 0");

    select_enable_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(&o_range_select_n) |-> $past(i_select_enable))
        else $error("range select without select enable");

    wait_ready_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(o_generated_ready_n) |-> $past(q.cnt) == $past(q.lim) && $past(q.state) == ST_WAIT)
        else $error("generated ready not at wait count");

    cycle_release_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        q.state == ST_DONE && (q.grant_cyc || q.size != `SIZE_DOUBLE || q.second)
        |=> o_boot_select_n && &o_range_select_n && q.cnt == '0)
        else $error("select or wait count kept after cycle end");

    start_aligned_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        $fell(o_cycle_strobe_n)
        |-> (q.second ? q.addr[2:0] == 3'h4 : aligned(q.size, q.addr)))
        else $error("misaligned access started");

    narrow_data_a: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        q.width == `WIDTH_8 |-> o_data_oe[31:8] == '0)
        else $error("upper data lines driven on 8-bit bus");

endmodule : ext_bus_unit

// ==== hdl/ebus_defs.svh ====
`ifndef EBUS_DEFS_SVH
`define EBUS_DEFS_SVH

// counts of selects and field widths
`define RANGE_CNT 5
`define SEL_CNT 6
`define BOOT_SEL 0
`define WAIT_W 4
`define SID_W 4
`define WADR_W 26
`define DRAM_W 12

// address bit positions
`define WADR_MSB 27
`define WADR_LSB 2
`define DRAM_ROW_MSB 25
`define DRAM_ROW_LSB 14
`define DRAM_COL_MSB 13
`define TOP_ZERO 4'h0
`define WORD_STEP 32'h4

// bus width codes
`define WIDTH_8 2'h0
`define WIDTH_16 2'h1
`define WIDTH_32 2'h2
`define MASK_8 32'h0000_00ff
`define MASK_16 32'h0000_ffff
`define MASK_32 32'hffff_ffff

// access size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`define SIZE_DOUBLE 2'h3

// lane numbers and idle level of active-low pins
`define LANE2 2'h2
`define LANE3 2'h3
`define INACTIVE_N 1'b1

`endif

// ==== hdl/ebus_pkg.sv ====
package ebus_pkg;
`include "ebus_defs.svh"

    typedef logic [31:0] addr_t;
    typedef logic [`WAIT_W-1:0] wait_t;
    typedef addr_t [`RANGE_CNT-1:0] range_arr_t;
    typedef wait_t [`SEL_CNT-1:0] wait_arr_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } bus_st_e;

    // one synchroniser stage of every pin input
    typedef struct packed {
        logic [`WADR_W-1:0] wadr;
        logic [`SID_W-1:0] sid;
        logic strobe_n;
        logic ready_n;
        logic [31:0] data;
        logic grant;
        logic psel;
    } pins_s;

    typedef struct packed {
        bus_st_e state;
        pins_s s1;
        pins_s s2;
        addr_t addr;
        logic [`SID_W-1:0] asi;
        logic write;
        logic [1:0] size;
        logic [1:0] width;
        logic dram;
        logic psel;
        logic [31:0] wdata2;
        logic second;
        logic grant_cyc;
        wait_t cnt;
        wait_t lim;
        logic [`WADR_W-1:0] adr_out;
        logic adr_oe;
        logic [`SID_W-1:0] sid_out;
        logic sid_oe;
        logic strobe_n;
        logic strobe_oe;
        logic lane2_n;
        logic lane3_n;
        logic [31:0] dat_out;
        logic [31:0] dat_oe;
        logic gen_rdy_n;
        logic boot_n;
        logic [`RANGE_CNT-1:0] range_n;
        logic busy;
        logic granted;
        logic ack;
        logic [31:0] rdata;
        logic misalign;
    } bus_s;

endpackage : ebus_pkg

// ==== hdl/cs_if.sv ====
`timescale 1ns/1ps
`include "ebus_defs.svh"
// address and range settings in, selects and wait limit out
interface cs_if;
    import ebus_pkg::*;
    addr_t addr;
    logic enable;
    range_arr_t base;
    range_arr_t mask;
    wait_arr_t waits;
    logic [`SEL_CNT-1:0] sel;
    wait_t lim;
    modport decoder(input addr, enable, base, mask, waits, output sel, lim);
    modport user(output addr, enable, base, mask, waits, input sel, lim);
endinterface : cs_if

// ==== hdl/range_decode.sv ====
`timescale 1ns/1ps
`include "ebus_defs.svh"
module range_decode (
    cs_if.decoder bus
);
    import ebus_pkg::*;

    logic [`SEL_CNT-1:0] sel_v;
    wait_t lim_v;
    logic found;

    // address bits under a set mask bit are ignored
    function automatic logic in_range(addr_t a, addr_t b, addr_t m);
        return ((a ^ b) & ~m) == '0;
    endfunction : in_range

    // lowest numbered matching range wins; boot select takes the rest
    always_comb begin
        sel_v = '0;
        lim_v = bus.waits[`BOOT_SEL];
        found = 1'b0;
        for (int k = 0; k < `RANGE_CNT; k++) begin
            if (!found && bus.enable && in_range(bus.addr, bus.base[k], bus.mask[k])) begin
                sel_v[k+1] = 1'b1;
                lim_v = bus.waits[k+1];
                found = 1'b1;
            end
        end
        if (!found) begin
            sel_v[`BOOT_SEL] = 1'b1;
        end
    end

    assign bus.sel = sel_v;
    assign bus.lim = lim_v;

endmodule : range_decode

// ==== verification/ebus_mem_model.sv ====
`timescale 1ns/1ps
// far-side memory: small word store with an optional early ready
module ebus_mem_model (
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic i_fast,
    input wire logic [25:0] i_address,
    input wire logic i_strobe_n,
    input wire logic i_selected,
    input wire logic [31:0] i_data,
    input wire logic [31:0] i_data_oe,
    output logic [31:0] o_data,
    output logic o_ready_n
);
    logic [31:0] mem_q [16];
    logic [3:0] idx_q;
    logic [3:0] idx;
    logic [31:0] last_q;
    // word index taken at the strobe only, idle address is junk
    assign idx = i_strobe_n ? idx_q : i_address[3:0];
    // drive only while selected, else a value that flips each clock
    assign o_data = i_selected ? mem_q[idx] : ~last_q;
    // store, ready timing and the released-bus pattern
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < 16; i++) begin
                mem_q[i] <= 32'h5a5a_5a50 | 32'(i);
            end
            idx_q <= 4'h0;
            last_q <= 32'h0;
            o_ready_n <= 1'b1;
        end else begin
            idx_q <= idx;
            last_q <= o_data;
            o_ready_n <= !(i_fast && !i_strobe_n);
            if (!i_strobe_n) begin
                // only the lines that the device drives are kept
                mem_q[idx] <= (mem_q[idx] & ~i_data_oe) | (i_data & i_data_oe);
            end
        end
    end
endmodule : ebus_mem_model

// ==== verification/external_bus_address_chip_select_tb_top.sv ====
`timescale 1ns/1ps
`include "ebus_defs.svh"
module external_bus_address_chip_select_tb_top;
    import ebus_pkg::*;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
    logic clk = 0, rst_n = 0, req = 0, wr = 0, dram = 0, sel_en = 1, psel = 1, gnt = 0;
    logic fast = 0, gm_stb_n = 1;
    addr_t req_addr = 0, a;
    logic [3:0] asi = 4'h3, gm_sid = 4'h0;
    logic [1:0] sz = 0, bw = `WIDTH_32;
    logic [31:0] wd = 0, wd2 = 0, mdl_d, dat_w;
    range_arr_t base, mask;
    wait_arr_t waits;
    logic [25:0] gm_adr = 26'h2aa_aaaa, adr_w;
    logic [3:0] sid_w;
    logic stb_w, busy, gntd, ack, mis, a_oe, s_oe, stb, stb_oe, l2, l3, gr_n, boot_n, rdy_n;
    logic [31:0] rdata, d_out, d_oe;
    logic [25:0] a_out, s_adr, s_nxt, s_last;
    logic [3:0] s_out, s_sid;
    logic [4:0] rng_n;
    logic [31:0] s_dout, s_doe, s_dlast;
    logic [5:0] s_sel;
    logic s_l2, s_l3;
    int fails = 0, comparisons = 0, n, nstb, ngr, acks;
    addr_t mis_a [3] = '{32'h1001, 32'h1002, 32'h1004};
    logic [1:0] mis_s [3] = '{`SIZE_HALF, `SIZE_WORD, `SIZE_DOUBLE};

    // two-way pins resolved from both parties
    assign adr_w = a_oe ? a_out : gm_adr;
    assign sid_w = s_oe ? s_out : gm_sid;
    assign stb_w = stb_oe ? stb : gm_stb_n;
    assign dat_w = (d_oe & d_out) | (~d_oe & mdl_d);

    ext_bus_unit dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_req(req), .i_req_addr(req_addr),
        .i_req_asi(asi), .i_req_write(wr), .i_req_size(sz), .i_req_wdata(wd),
        .i_req_wdata2(wd2), .o_busy(busy), .o_granted(gntd), .o_ack(ack),
        .o_rdata(rdata), .o_misalign(mis), .i_bus_width(bw), .i_dram_enable(dram),
        .i_select_enable(sel_en), .i_range_base_setting(base), .i_range_mask(mask),
        .i_wait_count(waits), .i_address_in(adr_w), .o_address_out(a_out),
        .o_address_oe(a_oe), .i_space_in(sid_w), .o_space_out(s_out), .o_space_oe(s_oe),
        .i_space_pin_select(psel), .i_cycle_strobe_n(stb_w), .o_cycle_strobe_n(stb),
        .o_cycle_strobe_oe(stb_oe), .o_byte_lane2_enable_n(l2),
        .o_byte_lane3_enable_n(l3), .i_data_in(dat_w), .o_data_out(d_out),
        .o_data_oe(d_oe), .i_ready_n(rdy_n), .o_generated_ready_n(gr_n),
        .o_boot_select_n(boot_n), .o_range_select_n(rng_n), .i_bus_grant(gnt)
    );

    ebus_mem_model mem (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_fast(fast), .i_address(adr_w),
        .i_strobe_n(stb_w), .i_selected(~&{boot_n, rng_n}), .i_data(d_out),
        .i_data_oe(d_oe), .o_data(mdl_d), .o_ready_n(rdy_n)
    );

    // clock and hang guard
    initial begin
        forever #10 clk = ~clk;
    end
    initial begin
        #100000;
        fails++;
        test_done();
    end

    task automatic step();
        @(posedge clk);
        #1;
    endtask : step

    // one core request, watched until its acks or a refusal
    task automatic access(input addr_t ad, input logic w, input logic [1:0] s,
            input logic [31:0] d, input logic [31:0] d2);
        req = 1;
        req_addr = ad;
        wr = w;
        sz = s;
        wd = d;
        wd2 = d2;
        n = 0;
        nstb = 0;
        ngr = 0;
        acks = 0;
        do begin
            step();
            req = 0;
            n++;
            if (n == 2) s_nxt = a_out;
            if (gr_n === 1'b0) ngr++;
            if (ack === 1'b1) acks++;
            if (stb === 1'b0) begin
                if (nstb == 0) begin
                    s_adr = a_out;
                    s_sid = s_out;
                    s_dout = d_out;
                    s_doe = d_oe;
                    s_sel = {rng_n, boot_n};
                    s_l2 = l2;
                    s_l3 = l3;
                end
                nstb++;
                s_last = a_out;
                s_dlast = d_out;
            end
        end while (acks < (s == `SIZE_DOUBLE ? 2 : 1) && mis !== 1'b1 && n < 40);
        `CHK("idle", 1'b0, busy)
        `CHK("sel_end", 6'h3f, {rng_n, boot_n})
    endtask : access

    task automatic test_done();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // main sequence
    initial begin
        waits[0] = 4'h2;
        for (int k = 0; k < 5; k++) begin
            base[k] = 32'h1000 * (k + 1);
            mask[k] = 32'h0000_0fff;
            waits[k + 1] = 4'(k + 1);
        end
        repeat (5) @(posedge clk);
        #1 rst_n = 1;
        `CHK("rst_oe", 3'h0, {a_oe, s_oe, stb_oe})
        `CHK("rst_sel", 6'h3f, {rng_n, boot_n})
        // each range: strobe, pins, select, own wait count, data
        for (int k = 1; k <= 5; k++) begin
            a = addr_t'(k * 32'h1004);
            access(a, 1, `SIZE_WORD, 32'ha5a5_0000 | 32'(k), 0);
            `CHK("lat", 3 + k, n)
            `CHK("gen", 1, ngr)
            `CHK("strobes", 1, nstb)
            `CHK("adr", a[27:2], s_adr)
            `CHK("sid", 4'h3, s_sid)
            `CHK("sel", 6'h3f & ~(6'h1 << k), s_sel)
            `CHK("doe", `MASK_32, s_doe)
            `CHK("dout", 32'ha5a5_0000 | 32'(k), s_dout)
            access(a, 0, `SIZE_WORD, 0, 0);
            `CHK("rd", 32'ha5a5_0000 | 32'(k), rdata)
        end
        sel_en = 0;
        access(32'h1004, 0, `SIZE_WORD, 0, 0);
        `CHK("sel_off", 6'h3e, s_sel)
        sel_en = 1;
        access(32'h0010_0000, 0, `SIZE_WORD, 0, 0);
        `CHK("boot", 6'h3e, s_sel)
        `CHK("boot_lat", 5, n)
        psel = 0;
        repeat (3) step();
        access(32'h6000_0000, 0, `SIZE_WORD, 0, 0);
        `CHK("sid_adr", 4'h6, s_sid)
        psel = 1;
        repeat (3) step();
        foreach (mis_a[i]) begin
            access(mis_a[i], 1, mis_s[i], 0, 0);
            `CHK("refuse", 1'b1, mis)
            `CHK("no_stb", 0, nstb)
        end
        access(32'h1008, 1, `SIZE_DOUBLE, 32'h1111_2222, 32'h3333_4444);
        `CHK("dbl_acks", 2, acks)
        `CHK("dbl_adr", 26'h402, s_adr)
        `CHK("dbl_adr2", 26'h403, s_last)
        `CHK("dbl_d2", 32'h3333_4444, s_dlast)
        // narrow buses: low lines only, address bits 1 and 0 on the lanes
        bw = `WIDTH_8;
        access(32'h1031, 1, `SIZE_BYTE, 32'h00ab_0000, 0);
        `CHK("b_oe", `MASK_8, s_doe)
        `CHK("b_dat", 8'hab, s_dout[7:0])
        `CHK("b_lane", 2'b01, {s_l2, s_l3})
        access(32'h1031, 0, `SIZE_BYTE, 0, 0);
        `CHK("b_rd", 32'h0000_00ab, rdata)
        bw = `WIDTH_16;
        access(32'h1042, 1, `SIZE_HALF, 32'h0000_beef, 0);
        `CHK("h_oe", `MASK_16, s_doe)
        `CHK("h_dat", 16'hbeef, s_dout[15:0])
        `CHK("h_lane", 2'b10, {s_l2, s_l3})
        access(32'h1042, 0, `SIZE_HALF, 0, 0);
        `CHK("h_rd", 32'h0000_beef, rdata)
        bw = `WIDTH_32;
        dram = 1;
        a = 32'h0123_4568;
        access(a, 1, `SIZE_WORD, 32'h0, 0);
        `CHK("row", a[25:14], s_adr[11:0])
        `CHK("col", a[13:2], s_nxt[11:0])
        dram = 0;
        fast = 1;
        access(32'h5014, 1, `SIZE_WORD, 32'h7, 0);
        `CHK("early", 1'b1, n < 8)
        `CHK("no_gen", 0, ngr)
        fast = 0;
        // outside master: pins released, its strobe drives selects and waits
        gnt = 1;
        psel = 0;
        gm_sid = 4'hf;
        gm_adr = 26'h400;
        repeat (4) step();
        access(32'h2000, 1, `SIZE_WORD, 0, 0);
        `CHK("g_ign", 0, nstb + acks)
        `CHK("g_oe", 3'h0, {a_oe, s_oe, stb_oe})
        `CHK("g_gnt", 1'b1, gntd)
        gm_stb_n = 0;
        step();
        gm_stb_n = 1;
        nstb = 0;
        ngr = 0;
        acks = 0;
        repeat (12) begin
            step();
            if (rng_n[0] === 1'b0) nstb++;
            if (gr_n === 1'b0) ngr++;
            if (boot_n === 1'b0) acks++;
        end
        `CHK("g_sel", 3, nstb)
        `CHK("g_rdy", 1, ngr)
        `CHK("g_boot", 0, acks)
        gnt = 0;
        psel = 1;
        repeat (4) step();
        test_done();
    end
endmodule : external_bus_address_chip_select_tb_top
